// File: src/cfg_bank_pkg.sv
// constants, register map and reset values of the converter config bank
// Behaviour
// - decode user addresses only from 0x000 up to 0x15D; map is sparse
// - registers read/write except the last four, read-only factory data
// - each read/write register is eight bits of volatile storage
// - defaults load at power-up and whenever the reset pin asserts
// - every register reached by a command carrying its address
// - 0x00 mirrored: shutdown, lsb-first, soft reset low, standby; 0x24
// - unused bit 7 of 0x59, 0x5A..0x5D and 0x62 always reads as zero
// - 0x01: rate enable b7, channel count b5..3, factory 111; 0x0F
// - 0x04: readback timing b7, factory 0011111 below; 0x9F
// - 0x07: word clock pol, autocal delay en, factory, randomizer; 0x62
// - 0x59: ref divider enable b4, synth enable b1, b7 unused; 0x41
// - 0x5F: synth output enable b3, bias enable b2; 0xF1
// - 0x5A: five-bit loop resistor, b7 unused, factory 01; 0x2F
// - 0x62: octal lvds, format, output mode, test pattern; 0x10
// - 0x65: eight lane polarity invert bits; 0x00
// - registers also reload defaults 2^20 clocks after power-on reset
package cfg_bank_pkg;
	localparam int ADDR_W = 10;
	localparam int NREG = 27;
	localparam int IDX_W = 5;
	localparam logic [ADDR_W-1:0] ADDR_MAX = 10'h15D;
	localparam int POR_DELAY_CYCLES = 1048576;
	localparam int POR_CNT_W = 21;

	// storage index of the first read-only factory register
	localparam logic [IDX_W-1:0] RO_FIRST = 5'h17;

	localparam logic [ADDR_W-1:0] BIT_ORDER_AND_POWER_MODE = 10'h000;
	localparam logic [ADDR_W-1:0] CHANNEL_COUNT_CONTROL = 10'h001;
	localparam logic [ADDR_W-1:0] OUTPUT_RATE_CONTROL = 10'h002;
	localparam logic [ADDR_W-1:0] READBACK_TIMING_CONTROL = 10'h004;
	localparam logic [ADDR_W-1:0] RANDOMIZER_AND_WORD_CLOCK = 10'h007;
	localparam logic [ADDR_W-1:0] AUTOCAL_DELAY = 10'h01E;
	localparam logic [ADDR_W-1:0] DELAY_LOOP_CONTROL = 10'h052;
	localparam logic [ADDR_W-1:0] CLOCK_SOURCE_SELECT = 10'h053;
	localparam logic [ADDR_W-1:0] SYNTH_REF_DIVIDER_LOW = 10'h054;
	localparam logic [ADDR_W-1:0] SYNTH_OUT_AND_REF_DIVIDER_HIGH = 10'h055;
	localparam logic [ADDR_W-1:0] SYNTH_PRESCALER_LOW = 10'h056;
	localparam logic [ADDR_W-1:0] SYNTH_PRESCALER_HIGH = 10'h057;
	localparam logic [ADDR_W-1:0] SYNTH_CHARGE_PUMP = 10'h058;
	localparam logic [ADDR_W-1:0] SYNTH_ENABLE_ONE = 10'h059;
	localparam logic [ADDR_W-1:0] LOOP_FILTER_RESISTOR = 10'h05A;
	localparam logic [ADDR_W-1:0] LOOP_FILTER_CAP_THREE = 10'h05B;
	localparam logic [ADDR_W-1:0] LOOP_FILTER_CAP_ONE = 10'h05C;
	localparam logic [ADDR_W-1:0] LOOP_FILTER_CAP_TWO = 10'h05D;
	localparam logic [ADDR_W-1:0] SYNTH_ENABLE_TWO = 10'h05F;
	localparam logic [ADDR_W-1:0] OUTPUT_FORMAT_AND_PATTERN = 10'h062;
	localparam logic [ADDR_W-1:0] RESOLUTION_AND_LVDS_LOAD = 10'h063;
	localparam logic [ADDR_W-1:0] DECIMATION_CLOCK_PHASE = 10'h064;
	localparam logic [ADDR_W-1:0] LVDS_POLARITY = 10'h065;
	// last four addresses of the map hold factory read-only data
	localparam logic [ADDR_W-1:0] FACTORY_RO_0 = 10'h15A;
	localparam logic [ADDR_W-1:0] FACTORY_RO_1 = 10'h15B;
	localparam logic [ADDR_W-1:0] FACTORY_RO_2 = 10'h15C;
	localparam logic [ADDR_W-1:0] FACTORY_RO_3 = 10'h15D;

	// defaults, in storage index order
	localparam logic [7:0] RST_BIT_ORDER = 8'h24;
	localparam logic [7:0] RST_CHANNEL_COUNT = 8'h0F;
	localparam logic [7:0] RST_OUTPUT_RATE = 8'h00;
	localparam logic [7:0] RST_READBACK_TIMING = 8'h9F;
	localparam logic [7:0] RST_RANDOMIZER = 8'h62;
	localparam logic [7:0] RST_AUTOCAL_DELAY = 8'h80;
	localparam logic [7:0] RST_DELAY_LOOP = 8'h0A;
	localparam logic [7:0] RST_CLOCK_SOURCE = 8'h45;
	localparam logic [7:0] RST_REF_DIV_LOW = 8'h00;
	localparam logic [7:0] RST_REF_DIV_HIGH = 8'h48;
	localparam logic [7:0] RST_PRESCALER_LOW = 8'h78;
	localparam logic [7:0] RST_PRESCALER_HIGH = 8'h40;
	localparam logic [7:0] RST_CHARGE_PUMP = 8'h12;
	localparam logic [7:0] RST_SYNTH_ENABLE_ONE = 8'h41;
	localparam logic [7:0] RST_LOOP_RESISTOR = 8'h2F;
	localparam logic [7:0] RST_LOOP_CAP = 8'h27;
	localparam logic [7:0] RST_SYNTH_ENABLE_TWO = 8'hF1;
	localparam logic [7:0] RST_OUTPUT_FORMAT = 8'h10;
	localparam logic [7:0] RST_RESOLUTION = 8'h01;
	localparam logic [7:0] RST_DECIM_PHASE = 8'h03;
	localparam logic [7:0] RST_LVDS_POLARITY = 8'h00;

	// bits that read back as stored; unimplemented bits masked to zero
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_BIT7_UNUSED = 8'h7F;

	// field positions
	localparam int BIT_SHUTDOWN_HI = 7;
	localparam int BIT_LSB_FIRST_HI = 6;
	localparam int BIT_SOFT_RESET_HI = 5;
	localparam int BIT_STANDBY_HI = 4;
	localparam int BIT_STANDBY_LO = 3;
	localparam int BIT_SOFT_RESET_LO = 2;
	localparam int BIT_LSB_FIRST_LO = 1;
	localparam int BIT_SHUTDOWN_LO = 0;
	localparam int BIT_INDEP_RATE = 7;
	localparam int POS_CHAN_COUNT = 3;
	localparam int BIT_READBACK_TIME = 7;
	localparam int BIT_WORD_CLK_POL = 7;
	localparam int BIT_AUTOCAL_EN = 6;
	localparam int BIT_RANDOMIZER = 0;
	localparam int BIT_REF_DIV_EN = 4;
	localparam int BIT_SYNTH_EN = 1;
	localparam int BIT_SYNTH_OUT_EN = 3;
	localparam int BIT_SYNTH_BIAS_EN = 2;
	localparam int BIT_OCTAL_LVDS = 6;
	localparam int BIT_DATA_FORMAT = 5;
	localparam int POS_OUT_MODE = 3;
	localparam int POS_TEST_PATTERN = 0;

	typedef enum logic [1:0] {
		POR_WAIT = 2'b00,
		POR_LOAD = 2'b01,
		POR_DONE = 2'b11
	} por_state_e;
endpackage

// File: src/cfg_factory_rom.sv
// factory read-only data with registered output
`timescale 1ns/1ps
module cfg_factory_rom #(
	parameter logic [7:0] FACTORY_0 = 8'h5A,
	parameter logic [7:0] FACTORY_1 = 8'hA5,
	parameter logic [7:0] FACTORY_2 = 8'h3C,
	parameter logic [7:0] FACTORY_3 = 8'hC3
) (
	// clock
	input  wire logic       clk,
	// read
	input  wire logic [1:0] sel,
	output logic      [7:0] data
);
	logic [7:0] data_d;

	always_comb begin
		case (sel)
			2'h0: data_d = FACTORY_0;
			2'h1: data_d = FACTORY_1;
			2'h2: data_d = FACTORY_2;
			default: data_d = FACTORY_3;
		endcase
	end

	always_ff @(posedge clk) begin
		data <= data_d;
	end
endmodule

// File: src/cfg_reg_mem.sv
// eight-bit storage array with per-index defaults and registered read
`timescale 1ns/1ps
module cfg_reg_mem (
	// clock and load of defaults
	input  wire logic                          clk,
	input  wire logic                          load_defaults,
	// write port
	input  wire logic                          wr_en,
	input  wire logic [cfg_bank_pkg::IDX_W-1:0] wr_idx,
	input  wire logic [7:0]                    wr_data,
	// read port
	input  wire logic [cfg_bank_pkg::IDX_W-1:0] rd_idx,
	output logic      [7:0]                    rd_data,
	// whole array for field taps
	output logic      [cfg_bank_pkg::NREG*8-1:0] flat
);
	logic [7:0] mem_q [cfg_bank_pkg::NREG];
	logic [7:0] mem_d [cfg_bank_pkg::NREG];
	logic [7:0] rd_d;

	function automatic logic [7:0] default_of(input int i);
		case (i)
			0: default_of = cfg_bank_pkg::RST_BIT_ORDER;
			1: default_of = cfg_bank_pkg::RST_CHANNEL_COUNT;
			2: default_of = cfg_bank_pkg::RST_OUTPUT_RATE;
			3: default_of = cfg_bank_pkg::RST_READBACK_TIMING;
			4: default_of = cfg_bank_pkg::RST_RANDOMIZER;
			5: default_of = cfg_bank_pkg::RST_AUTOCAL_DELAY;
			6: default_of = cfg_bank_pkg::RST_DELAY_LOOP;
			7: default_of = cfg_bank_pkg::RST_CLOCK_SOURCE;
			8: default_of = cfg_bank_pkg::RST_REF_DIV_LOW;
			9: default_of = cfg_bank_pkg::RST_REF_DIV_HIGH;
			10: default_of = cfg_bank_pkg::RST_PRESCALER_LOW;
			11: default_of = cfg_bank_pkg::RST_PRESCALER_HIGH;
			12: default_of = cfg_bank_pkg::RST_CHARGE_PUMP;
			13: default_of = cfg_bank_pkg::RST_SYNTH_ENABLE_ONE;
			14: default_of = cfg_bank_pkg::RST_LOOP_RESISTOR;
			15, 16, 17: default_of = cfg_bank_pkg::RST_LOOP_CAP;
			18: default_of = cfg_bank_pkg::RST_SYNTH_ENABLE_TWO;
			19: default_of = cfg_bank_pkg::RST_OUTPUT_FORMAT;
			20: default_of = cfg_bank_pkg::RST_RESOLUTION;
			21: default_of = cfg_bank_pkg::RST_DECIM_PHASE;
			default: default_of = cfg_bank_pkg::RST_LVDS_POLARITY;
		endcase
	endfunction

	always_comb begin
		for (int i = 0; i < cfg_bank_pkg::NREG; i++) begin
			if (load_defaults) begin
				mem_d[i] = default_of(i);
			end else if (wr_en && wr_idx == i[cfg_bank_pkg::IDX_W-1:0]) begin
				mem_d[i] = wr_data;
			end else begin
				mem_d[i] = mem_q[i];
			end
		end
		rd_d = mem_q[rd_idx];
	end

	always_ff @(posedge clk) begin
		mem_q <= mem_d;
		rd_data <= rd_d;
	end

	always_comb begin
		for (int i = 0; i < cfg_bank_pkg::NREG; i++) begin
			flat[i*8 +: 8] = mem_q[i];
		end
	end
endmodule

// File: src/adc_config_register_bank.sv
// configuration register bank of the converter, top level
`timescale 1ns/1ps
module adc_config_register_bank #(
	parameter int POR_DELAY = cfg_bank_pkg::POR_DELAY_CYCLES
) (
	// clock and reset pin
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	// register command port from the serial front end
	input  wire logic       CMD_VALID,
	input  wire logic       CMD_WRITE,
	input  wire logic [9:0] CMD_ADDR,
	input  wire logic [7:0] CMD_WDATA,
	output logic            RD_VALID,
	output logic      [7:0] RD_DATA,
	output logic            RD_HIT,
	// decoded controls
	output logic            SHUTDOWN,
	output logic            STANDBY,
	output logic            SOFT_RESET,
	output logic            LSB_FIRST,
	output logic            INDEPENDENT_RATE_ENABLE,
	output logic      [2:0] CHANNEL_COUNT_SEL,
	output logic            READBACK_OUTPUT_TIMING,
	output logic            WORD_CLOCK_POLARITY,
	output logic            AUTOCAL_DELAY_ENABLE,
	output logic            RANDOMIZER_ENABLE,
	output logic            SYNTH_REF_DIVIDER_ENABLE,
	output logic            SYNTH_ENABLE,
	output logic            SYNTH_OUTPUT_ENABLE,
	output logic            SYNTH_BIAS_ENABLE,
	output logic      [4:0] LOOP_FILTER_RESISTOR_SETTING,
	output logic            OCTAL_SERIAL_LVDS_SELECT,
	output logic            DATA_FORMAT,
	output logic      [1:0] OUTPUT_MODE,
	output logic      [2:0] TEST_PATTERN_SEL,
	output logic      [7:0] LVDS_LANE_INVERT,
	output logic            DEFAULTS_READY
);
	// decode result: storage index, valid, read-only
	typedef struct packed {
		logic                          hit;
		logic                          ro;
		logic [cfg_bank_pkg::IDX_W-1:0] idx;
		logic [7:0]                    mask;
	} dec_s;

	function automatic dec_s decode(input logic [9:0] a);
		dec_s r;
		r.hit = 1'b1;
		r.ro = 1'b0;
		r.mask = cfg_bank_pkg::MASK_ALL;
		if (a == cfg_bank_pkg::BIT_ORDER_AND_POWER_MODE) begin
			r.idx = 5'h00;
		end else if (a == cfg_bank_pkg::CHANNEL_COUNT_CONTROL) begin
			r.idx = 5'h01;
		end else if (a == cfg_bank_pkg::OUTPUT_RATE_CONTROL) begin
			r.idx = 5'h02;
		end else if (a == cfg_bank_pkg::READBACK_TIMING_CONTROL) begin
			r.idx = 5'h03;
		end else if (a == cfg_bank_pkg::RANDOMIZER_AND_WORD_CLOCK) begin
			r.idx = 5'h04;
		end else if (a == cfg_bank_pkg::AUTOCAL_DELAY) begin
			r.idx = 5'h05;
		end else if (a == cfg_bank_pkg::DELAY_LOOP_CONTROL) begin
			r.idx = 5'h06;
		end else if (a == cfg_bank_pkg::CLOCK_SOURCE_SELECT) begin
			r.idx = 5'h07;
		end else if (a == cfg_bank_pkg::SYNTH_REF_DIVIDER_LOW) begin
			r.idx = 5'h08;
		end else if (a == cfg_bank_pkg::SYNTH_OUT_AND_REF_DIVIDER_HIGH) begin
			r.idx = 5'h09;
		end else if (a == cfg_bank_pkg::SYNTH_PRESCALER_LOW) begin
			r.idx = 5'h0A;
		end else if (a == cfg_bank_pkg::SYNTH_PRESCALER_HIGH) begin
			r.idx = 5'h0B;
		end else if (a == cfg_bank_pkg::SYNTH_CHARGE_PUMP) begin
			r.idx = 5'h0C;
		end else if (a == cfg_bank_pkg::SYNTH_ENABLE_ONE) begin
			r.idx = 5'h0D;
			r.mask = cfg_bank_pkg::MASK_BIT7_UNUSED;
		end else if (a == cfg_bank_pkg::LOOP_FILTER_RESISTOR) begin
			r.idx = 5'h0E;
			r.mask = cfg_bank_pkg::MASK_BIT7_UNUSED;
		end else if (a == cfg_bank_pkg::LOOP_FILTER_CAP_THREE) begin
			r.idx = 5'h0F;
			r.mask = cfg_bank_pkg::MASK_BIT7_UNUSED;
		end else if (a == cfg_bank_pkg::LOOP_FILTER_CAP_ONE) begin
			r.idx = 5'h10;
			r.mask = cfg_bank_pkg::MASK_BIT7_UNUSED;
		end else if (a == cfg_bank_pkg::LOOP_FILTER_CAP_TWO) begin
			r.idx = 5'h11;
			r.mask = cfg_bank_pkg::MASK_BIT7_UNUSED;
		end else if (a == cfg_bank_pkg::SYNTH_ENABLE_TWO) begin
			r.idx = 5'h12;
		end else if (a == cfg_bank_pkg::OUTPUT_FORMAT_AND_PATTERN) begin
			r.idx = 5'h13;
			r.mask = cfg_bank_pkg::MASK_BIT7_UNUSED;
		end else if (a == cfg_bank_pkg::RESOLUTION_AND_LVDS_LOAD) begin
			r.idx = 5'h14;
		end else if (a == cfg_bank_pkg::DECIMATION_CLOCK_PHASE) begin
			r.idx = 5'h15;
		end else if (a == cfg_bank_pkg::LVDS_POLARITY) begin
			r.idx = 5'h16;
		end else if (a >= cfg_bank_pkg::FACTORY_RO_0 &&
			a <= cfg_bank_pkg::ADDR_MAX) begin
			r.idx = cfg_bank_pkg::RO_FIRST + 5'(a - cfg_bank_pkg::FACTORY_RO_0);
			r.ro = 1'b1;
		end else begin
			// unmapped: no hit, reads back zero
			r.hit = 1'b0;
			r.idx = 5'h00;
			r.mask = 8'h00;
		end
		return r;
	endfunction

	// power-on delay then default load
	cfg_bank_pkg::por_state_e por_q, por_d;
	logic [cfg_bank_pkg::POR_CNT_W-1:0] cnt_q, cnt_d;
	logic load_defaults;

	always_comb begin
		por_d = por_q;
		cnt_d = cnt_q;
		case (por_q)
			cfg_bank_pkg::POR_WAIT: begin
				if (cnt_q == cfg_bank_pkg::POR_CNT_W'(POR_DELAY - 1)) begin
					por_d = cfg_bank_pkg::POR_LOAD;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			cfg_bank_pkg::POR_LOAD: begin
				por_d = cfg_bank_pkg::POR_DONE;
			end
			default: begin
				por_d = cfg_bank_pkg::POR_DONE;
			end
		endcase
	end

	// power-on state is taken from reset; reset pin also reruns the wait
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			por_q <= cfg_bank_pkg::POR_WAIT;
			cnt_q <= '0;
		end else begin
			por_q <= por_d;
			cnt_q <= cnt_d;
		end
	end

	// a write landing in the load cycle loses to the defaults
	// reset pin loads defaults
	assign load_defaults = SYS_RST || (por_q == cfg_bank_pkg::POR_LOAD);

	// command decode
	dec_s dec;
	logic wr_ok;
	logic [7:0] mem_rd, rom_rd;
	logic [1:0] rom_sel;
	logic [cfg_bank_pkg::NREG*8-1:0] flat;

	assign dec = decode(CMD_ADDR);
	assign wr_ok = CMD_VALID && CMD_WRITE && dec.hit && !dec.ro;

	cfg_reg_mem u_mem (
		.clk           (CLK),
		.load_defaults (load_defaults),
		.wr_en         (wr_ok),
		.wr_idx        (dec.idx),
		.wr_data       (CMD_WDATA),
		.rd_idx        (dec.idx),
		.rd_data       (mem_rd),
		.flat          (flat)
	);

	// rom words follow the address order from the first read-only location;
	// the low address bits alone would start the table mid-way
	assign rom_sel = 2'(CMD_ADDR - cfg_bank_pkg::FACTORY_RO_0);

	cfg_factory_rom u_rom (
		.clk  (CLK),
		.sel  (rom_sel),
		.data (rom_rd)
	);

	// read answer two cycles after the command
	logic       rvalid_q, rvalid_d;
	logic       rhit_q, rhit_d;
	logic       rro_q, rro_d;
	logic [7:0] rmask_q, rmask_d;

	always_comb begin
		rvalid_d = CMD_VALID && !CMD_WRITE && !SYS_RST;
		rhit_d = dec.hit;
		rro_d = dec.ro;
		rmask_d = dec.mask;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rvalid_q <= 1'b0;
			rhit_q <= 1'b0;
			rro_q <= 1'b0;
			rmask_q <= 8'h00;
		end else begin
			rvalid_q <= rvalid_d;
			rhit_q <= rhit_d;
			rro_q <= rro_d;
			rmask_q <= rmask_d;
		end
	end

	// second stage keeps every output straight from a flop
	logic       rv2_q, rv2_d;
	logic       rh2_q, rh2_d;
	logic [7:0] rdat_q, rdat_d;

	always_comb begin
		rv2_d = rvalid_q;
		rh2_d = rvalid_q && rhit_q;
		rdat_d = rvalid_q ? ((rro_q ? rom_rd : mem_rd) & rmask_q) : 8'h00;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rv2_q <= 1'b0;
			rh2_q <= 1'b0;
			rdat_q <= 8'h00;
		end else begin
			rv2_q <= rv2_d;
			rh2_q <= rh2_d;
			rdat_q <= rdat_d;
		end
	end

	assign RD_VALID = rv2_q;
	assign RD_HIT = rh2_q;
	assign RD_DATA = rdat_q;

	// field taps, registered
	logic [7:0] r00, r01, r04, r07, r59, r5a, r5f, r62, r65;
	assign r00 = flat[0*8 +: 8];
	assign r01 = flat[1*8 +: 8];
	assign r04 = flat[3*8 +: 8];
	assign r07 = flat[4*8 +: 8];
	assign r59 = flat[13*8 +: 8];
	assign r5a = flat[14*8 +: 8];
	assign r5f = flat[18*8 +: 8];
	assign r62 = flat[19*8 +: 8];
	assign r65 = flat[22*8 +: 8];

	logic [36:0] fld_q, fld_d;

	always_comb begin
		fld_d = '0;
		fld_d[0] = r00[cfg_bank_pkg::BIT_SHUTDOWN_HI] |
			r00[cfg_bank_pkg::BIT_SHUTDOWN_LO];
		fld_d[1] = r00[cfg_bank_pkg::BIT_STANDBY_HI] |
			r00[cfg_bank_pkg::BIT_STANDBY_LO];
		fld_d[2] = !r00[cfg_bank_pkg::BIT_SOFT_RESET_HI] |
			!r00[cfg_bank_pkg::BIT_SOFT_RESET_LO];
		fld_d[3] = r00[cfg_bank_pkg::BIT_LSB_FIRST_HI] |
			r00[cfg_bank_pkg::BIT_LSB_FIRST_LO];
		fld_d[4] = r01[cfg_bank_pkg::BIT_INDEP_RATE];
		fld_d[7:5] = r01[cfg_bank_pkg::POS_CHAN_COUNT +: 3];
		fld_d[8] = r04[cfg_bank_pkg::BIT_READBACK_TIME];
		fld_d[9] = r07[cfg_bank_pkg::BIT_WORD_CLK_POL];
		fld_d[10] = r07[cfg_bank_pkg::BIT_AUTOCAL_EN];
		fld_d[11] = r07[cfg_bank_pkg::BIT_RANDOMIZER];
		fld_d[12] = r59[cfg_bank_pkg::BIT_REF_DIV_EN];
		fld_d[13] = r59[cfg_bank_pkg::BIT_SYNTH_EN];
		fld_d[14] = r5f[cfg_bank_pkg::BIT_SYNTH_OUT_EN];
		fld_d[15] = r5f[cfg_bank_pkg::BIT_SYNTH_BIAS_EN];
		fld_d[20:16] = r5a[4:0];
		fld_d[21] = r62[cfg_bank_pkg::BIT_OCTAL_LVDS];
		fld_d[22] = r62[cfg_bank_pkg::BIT_DATA_FORMAT];
		fld_d[24:23] = r62[cfg_bank_pkg::POS_OUT_MODE +: 2];
		fld_d[27:25] = r62[cfg_bank_pkg::POS_TEST_PATTERN +: 3];
		fld_d[35:28] = r65;
		fld_d[36] = (por_q == cfg_bank_pkg::POR_DONE);
	end

	always_ff @(posedge CLK) begin
		fld_q <= fld_d;
	end

	assign SHUTDOWN = fld_q[0];
	assign STANDBY = fld_q[1];
	assign SOFT_RESET = fld_q[2];
	assign LSB_FIRST = fld_q[3];
	assign INDEPENDENT_RATE_ENABLE = fld_q[4];
	assign CHANNEL_COUNT_SEL = fld_q[7:5];
	assign READBACK_OUTPUT_TIMING = fld_q[8];
	assign WORD_CLOCK_POLARITY = fld_q[9];
	assign AUTOCAL_DELAY_ENABLE = fld_q[10];
	assign RANDOMIZER_ENABLE = fld_q[11];
	assign SYNTH_REF_DIVIDER_ENABLE = fld_q[12];
	assign SYNTH_ENABLE = fld_q[13];
	assign SYNTH_OUTPUT_ENABLE = fld_q[14];
	assign SYNTH_BIAS_ENABLE = fld_q[15];
	assign LOOP_FILTER_RESISTOR_SETTING = fld_q[20:16];
	assign OCTAL_SERIAL_LVDS_SELECT = fld_q[21];
	assign DATA_FORMAT = fld_q[22];
	assign OUTPUT_MODE = fld_q[24:23];
	assign TEST_PATTERN_SEL = fld_q[27:25];
	assign LVDS_LANE_INVERT = fld_q[35:28];
	assign DEFAULTS_READY = fld_q[36];
endmodule

// File: bench/cfg_bank_properties.sv
// port checks of the converter config bank
`timescale 1ns/1ps
module cfg_bank_properties #(
	parameter int POR_DELAY = cfg_bank_pkg::POR_DELAY_CYCLES
) (
	// clock and reset
	input wire logic       CLK,
	input wire logic       SYS_RST,
	// command port
	input wire logic       CMD_VALID,
	input wire logic       CMD_WRITE,
	input wire logic [9:0] CMD_ADDR,
	input wire logic [7:0] CMD_WDATA,
	input wire logic       RD_VALID,
	input wire logic [7:0] RD_DATA,
	input wire logic       RD_HIT,
	// fields
	input wire logic       SHUTDOWN,
	input wire logic       STANDBY,
	input wire logic       SOFT_RESET,
	input wire logic       LSB_FIRST,
	input wire logic       OCTAL_SERIAL_LVDS_SELECT,
	input wire logic       DATA_FORMAT,
	input wire logic [1:0] OUTPUT_MODE,
	input wire logic [2:0] TEST_PATTERN_SEL,
	input wire logic [7:0] LVDS_LANE_INVERT,
	input wire logic       DEFAULTS_READY
);
	logic       rd1_q;
	logic       rd2_q;
	logic [7:0] wd1_q;
	logic [7:0] wd2_q;
	int         cnt_q;
	logic       wr;
	logic       rd;
	assign wr = CMD_VALID && CMD_WRITE;
	assign rd = CMD_VALID && !CMD_WRITE;
	default clocking cb @(posedge CLK); endclocking
	// delayed request and data, cycles since release
	always_ff @(posedge CLK) begin
		rd1_q <= rd && !SYS_RST;
		rd2_q <= rd1_q;
		wd1_q <= CMD_WDATA;
		wd2_q <= wd1_q;
		cnt_q <= SYS_RST ? 0 : cnt_q + 1;
	end
	AST_RD_LATENCY: assert property (disable iff (SYS_RST)
		rd ##1 !rd |-> ##1 RD_VALID ##1 !RD_VALID)
		else $error("read answer late");
	AST_RD_CAUSE: assert property (disable iff (SYS_RST)
		RD_VALID |-> rd2_q) else $error("answer without read");
	AST_UNMAPPED: assert property (disable iff (SYS_RST)
		rd && CMD_ADDR > 10'h15D |-> ##2 !RD_HIT && RD_DATA == 8'h00)
		else $error("unmapped read not empty");
	AST_RST_DEFAULTS: assert property (disable iff (1'b0)
		SYS_RST [*2] |=> !SOFT_RESET && OUTPUT_MODE == 2'h2 &&
		LVDS_LANE_INVERT == 8'h00) else $error("reset defaults wrong");
	AST_LANE_WRITE: assert property (disable iff (SYS_RST)
		wr && CMD_ADDR == 10'h065 && DEFAULTS_READY |->
		##2 LVDS_LANE_INVERT == wd2_q) else $error("lane invert wrong");
	AST_MIRROR: assert property (disable iff (SYS_RST)
		wr && CMD_ADDR == 10'h000 && DEFAULTS_READY |-> ##2
		SHUTDOWN == (wd2_q[7] | wd2_q[0]) &&
		LSB_FIRST == (wd2_q[6] | wd2_q[1]) &&
		SOFT_RESET == !(wd2_q[5] & wd2_q[2]) &&
		STANDBY == (wd2_q[4] | wd2_q[3])) else $error("mode bits wrong");
	AST_FORMAT: assert property (disable iff (SYS_RST)
		wr && CMD_ADDR == 10'h062 && DEFAULTS_READY |-> ##2
		{OCTAL_SERIAL_LVDS_SELECT, DATA_FORMAT, OUTPUT_MODE,
		TEST_PATTERN_SEL} == wd2_q[6:0]) else $error("format wrong");
	AST_IGNORED_WRITE: assert property (disable iff (SYS_RST)
		!($past(wr) && $past(CMD_ADDR) inside {10'h062, 10'h065}) &&
		wr && CMD_ADDR >= 10'h15A && DEFAULTS_READY |->
		##2 $stable(LVDS_LANE_INVERT) && $stable(TEST_PATTERN_SEL))
		else $error("ignored write changed state");
	AST_POWER_ON: assert property (disable iff (SYS_RST)
		$rose(DEFAULTS_READY) |-> cnt_q >= POR_DELAY - 1 &&
		cnt_q <= POR_DELAY + 2) else $error("power-on reload off time");
endmodule

bind adc_config_register_bank cfg_bank_properties #(
	.POR_DELAY(POR_DELAY)
) props_i (
	.CLK, .SYS_RST, .CMD_VALID, .CMD_WRITE, .CMD_ADDR, .CMD_WDATA,
	.RD_VALID, .RD_DATA, .RD_HIT, .SHUTDOWN, .STANDBY, .SOFT_RESET,
	.LSB_FIRST, .OCTAL_SERIAL_LVDS_SELECT, .DATA_FORMAT, .OUTPUT_MODE,
	.TEST_PATTERN_SEL, .LVDS_LANE_INVERT, .DEFAULTS_READY
);

// File: bench/cfg_host_model.sv
// host side issuing register commands to the bank
`timescale 1ns/1ps
module cfg_host_model (
	// clock
	input wire logic       clk,
	// commands
	output logic           cmd_valid,
	output logic           cmd_write,
	output logic     [9:0] cmd_addr,
	output logic     [7:0] cmd_wdata,
	// read answer
	input wire logic       rd_valid,
	input wire logic [7:0] rd_data,
	input wire logic       rd_hit
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 10'h000;
		cmd_wdata = 8'h00;
	end
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = 1'b1;
		cmd_addr = a;
		cmd_wdata = d;
	endtask
	// released lines toggle so stale values never pass
	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk);
			cmd_valid = 1'b0;
			cmd_addr = ~cmd_addr;
			cmd_wdata = ~cmd_wdata;
		end
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d,
		output logic h);
		d = 8'hXX;
		h = 1'bx;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = 1'b0;
		cmd_addr = a;
		idle(1);
		repeat (4) begin
			@(negedge clk);
			if (rd_valid === 1'b1) begin
				d = rd_data;
				h = rd_hit;
				break;
			end
		end
	endtask
endmodule

// File: bench/tb.sv
// self-checking bench of the converter config bank
`timescale 1ns/1ps
module tb;
	logic       clk, sys_rst, vld, wrt, rvld, hit, shd, stby, srst, lsb;
	logic       irate, octal, fmt, ready, h;
	logic       rbt, wcp, acd, rnd, rde, sen, soe, sbe;
	logic [9:0] adr;
	logic [7:0] wdat, rdat, inv, d, v, e;
	logic [2:0] chan, pat;
	logic [4:0] lres;
	logic [1:0] mode;
	int         num_errors;
	int         num_checks;
	logic [9:0] radr [23] = '{10'h000, 10'h001, 10'h002, 10'h004, 10'h007,
		10'h01E, 10'h052, 10'h053, 10'h054, 10'h055, 10'h056, 10'h057,
		10'h058, 10'h059, 10'h05A, 10'h05B, 10'h05C, 10'h05D, 10'h05F,
		10'h062, 10'h063, 10'h064, 10'h065};
	logic [7:0] dfl [23] = '{8'h24, 8'h0F, 8'h00, 8'h9F, 8'h62, 8'h80,
		8'h0A, 8'h45, 8'h00, 8'h48, 8'h78, 8'h40, 8'h12, 8'h41, 8'h2F,
		8'h27, 8'h27, 8'h27, 8'hF1, 8'h10, 8'h01, 8'h03, 8'h00};
	logic [7:0] rov [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
	logic [7:0] mir [9] = '{8'h80, 8'h01, 8'h40, 8'h02, 8'h04, 8'h20,
		8'h10, 8'h08, 8'h24};
	cfg_host_model host_i (.clk(clk), .cmd_valid(vld), .cmd_write(wrt),
		.cmd_addr(adr), .cmd_wdata(wdat), .rd_valid(rvld), .rd_data(rdat),
		.rd_hit(hit));
	adc_config_register_bank #(.POR_DELAY(16)) adc_config_register_bank_i (
		.CLK(clk), .SYS_RST(sys_rst), .CMD_VALID(vld), .CMD_WRITE(wrt),
		.CMD_ADDR(adr), .CMD_WDATA(wdat), .RD_VALID(rvld), .RD_DATA(rdat),
		.RD_HIT(hit), .SHUTDOWN(shd), .STANDBY(stby), .SOFT_RESET(srst),
		.LSB_FIRST(lsb), .INDEPENDENT_RATE_ENABLE(irate),
		.CHANNEL_COUNT_SEL(chan), .READBACK_OUTPUT_TIMING(rbt),
		.WORD_CLOCK_POLARITY(wcp), .AUTOCAL_DELAY_ENABLE(acd),
		.RANDOMIZER_ENABLE(rnd), .SYNTH_REF_DIVIDER_ENABLE(rde),
		.SYNTH_ENABLE(sen), .SYNTH_OUTPUT_ENABLE(soe),
		.SYNTH_BIAS_ENABLE(sbe),
		.LOOP_FILTER_RESISTOR_SETTING(lres),
		.OCTAL_SERIAL_LVDS_SELECT(octal), .DATA_FORMAT(fmt),
		.OUTPUT_MODE(mode), .TEST_PATTERN_SEL(pat),
		.LVDS_LANE_INVERT(inv), .DEFAULTS_READY(ready));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [7:0] ed,
		input logic eh);
		host_i.rd(a, d, h);
		chk(d, ed);
		chk({7'h00, h}, {7'h00, eh});
	endtask
	task automatic wait_ready();
		repeat (40) if (ready !== 1'b1) @(negedge clk);
		chk({7'h00, ready}, 8'h01);
	endtask
	task automatic chk_defaults();
		for (int i = 0; i < 23; i++) rdchk(radr[i], dfl[i], 1'b1);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// generous bound, the run needs about 360 cycles
	initial begin
		#100000;
		num_errors++;
		end_of_test();
	end
	initial begin
		sys_rst = 1'b1;
		num_errors = 0;
		num_checks = 0;
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		host_i.wr(10'h065, 8'hAA);
		rdchk(10'h065, 8'hAA, 1'b1);
		wait_ready();
		rdchk(10'h065, 8'h00, 1'b1);
		chk_defaults();
		for (int i = 0; i < 23; i++) host_i.wr(radr[i], 8'hFF);
		for (int i = 0; i < 23; i++) begin
			e = (radr[i] inside {10'h059, [10'h05A:10'h05D], 10'h062}) ?
				8'h7F : 8'hFF;
			rdchk(radr[i], e, 1'b1);
		end
		host_i.wr(10'h003, 8'hFF);
		host_i.wr(10'h15A, 8'h00);
		host_i.wr(10'h3FF, 8'hFF);
		host_i.idle(3);
		rdchk(10'h003, 8'h00, 1'b0);
		rdchk(10'h15E, 8'h00, 1'b0);
		rdchk(10'h3FF, 8'h00, 1'b0);
		for (int i = 0; i < 4; i++)
			rdchk(10'h15A + 10'(i), rov[i], 1'b1);
		for (int i = 0; i < 9; i++) begin
			v = mir[i];
			e = {4'h0, v[7] | v[0], v[6] | v[1], ~(v[5] & v[2]), v[4] | v[3]};
			host_i.wr(10'h000, v);
			host_i.idle(2);
			chk({4'h0, shd, lsb, srst, stby}, e);
		end
		// every mode and pattern code, varying host pace
		for (int i = 0; i < 8; i++) begin
			v = {1'b0, i[0], ~i[0], i[1:0], i[2:0]};
			host_i.wr(10'h062, v);
			host_i.idle(i % 3 + 2);
			chk({1'b0, octal, fmt, mode, pat}, v);
		end
		host_i.wr(10'h001, 8'hBF);
		host_i.wr(10'h05A, 8'h35);
		host_i.wr(10'h004, 8'h1F);
		host_i.wr(10'h007, 8'h23);
		host_i.wr(10'h059, 8'h53);
		host_i.wr(10'h05F, 8'hFD);
		host_i.idle(2);
		chk({4'h0, irate, chan}, 8'h0F);
		chk({3'h0, lres}, 8'h15);
		chk({7'h00, rbt}, 8'h00);
		chk({5'h00, wcp, acd, rnd}, 8'h01);
		chk({6'h00, rde, sen}, 8'h03);
		chk({6'h00, soe, sbe}, 8'h03);
		host_i.wr(10'h065, 8'h5C);
		rdchk(10'h065, 8'h5C, 1'b1);
		chk(inv, 8'h5C);
		@(negedge clk);
		sys_rst = 1'b1;
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		chk(inv, 8'h00);
		chk({rbt, wcp, acd, rnd, rde, sen, soe, sbe}, 8'hA0);
		chk_defaults();
		wait_ready();
		end_of_test();
	end
endmodule
